// *** common/sfps_params.svh ***
/*
  Constants for the slave FIFO port: widths, depths, reset values and
  timing counts. Assumes the including file compiles after this header.
*/
`ifndef SFPS_PARAMS_SVH
`define SFPS_PARAMS_SVH

`define SFPS_DATA_W 16
`define SFPS_ADDR_W 2
`define SFPS_LEN_W 10
`define SFPS_FIFO_DEPTH 4
`define SFPS_CLK_MHZ 20
`define SFPS_ADDR_SETUP_NS 25
// least time, rounded up to whole cycles, zero only for a zero time
`define SFPS_ADDR_SETUP_CYC \
  (((`SFPS_ADDR_SETUP_NS * `SFPS_CLK_MHZ) + 999) / 1000)
`define SFPS_RST_WORD 16'h0000
`define SFPS_RST_COUNT 10'h000

`endif

// *** common/sfps_pkg.sv ***
/*
  Types shared by the slave FIFO port: the buffered entry and the
  registered state of the port. Assumes sfps_params.svh is reachable.
*/
`include "sfps_params.svh"

package sfps_pkg;

  // one entry of the master-to-endpoint path: a word or a commit marker
  typedef struct packed {
    logic isData;
    logic last;
    logic [`SFPS_ADDR_W-1:0] addr;
    logic [`SFPS_DATA_W-1:0] data;
  } sfps_entry_s;

  // the whole registered state of the port sequencer
  typedef struct packed {
    logic clkPrev;
    logic wrPrev;
    logic rdPrev;
    logic pePrev;
    logic [`SFPS_DATA_W-1:0] dataInQ;
    logic [`SFPS_ADDR_W-1:0] addrQ;
    logic [`SFPS_LEN_W-1:0] wordCount;
    logic [`SFPS_DATA_W-1:0] rdData;
    logic drive;
  } sfps_port_s;

endpackage

// *** rtl/sfps_slave_fifo_port.sv ***
/*
  Slave FIFO data port: the master-facing sequencer and its 4-word
  buffers. Assumes every pin input is synchronous to clk, the interface
  clock being sampled as an ordinary input, and that the endpoint side
  drains and fills the buffers through valid/ready handshakes.
*/
// Behaviour
// - output enable only gates data drive, never moves the read pointer
// - sync mode keeps the head word prefetched and drives it on enable
// - a read starts only with chip select and read strobe both active
// - sync read edge advances pointer, then newly addressed word shows
// - burst read: each further edge with strobe held gives next word
// - read data is driven only while output enable is active; the code drives one clk behind enable, so a clk late at both ends
// - sync write edge stores bus word and bumps the write pointer
// - sync flags change after the edge that moved the pointer
// - a write starts only with chip select and write strobe active
// - commit on the last write edge includes that word; later is fine; the code includes it in sync mode only, not in async
// - auto mode commits once the word count reaches the set length
// - async enable before a read shows the previous read's word
// - async read asserting edge drives the head word then pops it
// - works with enable tied to read strobe and chip select tied on
// - async write release stores the word, then bumps the pointer
// - async flags change after each write strobe release
`timescale 1ns/1ps

module sfps_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [WIDTH-1:0] inData, // word to store
  input wire logic inValid, // store request
  output logic inReady, // room for one more word
  output logic [WIDTH-1:0] outData, // head word
  output logic outValid, // head word present
  input wire logic outReady // head word taken
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } sfps_fifo_st_s;

  sfps_fifo_st_s st;
  sfps_fifo_st_s next_st;
  logic doWrite;
  logic doRead;

  // full and empty come straight from the registered count
  assign inReady = (st.count != DEPTH[PW:0]);
  assign outValid = (st.count != '0);
  assign outData = st.mem[st.rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outReady && outValid;

  // pointer wrap handled explicitly so DEPTH need not be a power of two
  always_comb begin
    next_st = st;
    if (doWrite) begin
      next_st.mem[st.wrPtr] = inData;
      if (st.wrPtr == PW'(DEPTH - 1)) begin
        next_st.wrPtr = '0;
      end else begin
        next_st.wrPtr = st.wrPtr + 1'b1;
      end
    end
    if (doRead) begin
      if (st.rdPtr == PW'(DEPTH - 1)) begin
        next_st.rdPtr = '0;
      end else begin
        next_st.rdPtr = st.rdPtr + 1'b1;
      end
    end
    case ({doWrite, doRead})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  // storage needs no reset, only the pointers and count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st.mem <= st.mem;
      st.wrPtr <= '0;
      st.rdPtr <= '0;
      st.count <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

module sfps_slave_fifo_port
  import sfps_pkg::*;
(
  input wire logic clk, // system clock, 20 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic syncMode, // 1 clocked strobes, 0 edge strobes
  input wire logic strobeActiveHigh, // 1 turns all strobes active high
  input wire logic autoMode, // automatic commit on length
  input wire logic [`SFPS_LEN_W-1:0] autoCommitLength, // words per packet
  input wire logic interfaceClock, // master interface clock, sampled
  input wire logic fifoChipSelectN, // chip select
  input wire logic fifoOutputEnableN, // data bus output enable
  input wire logic fifoReadStrobeN, // read strobe
  input wire logic fifoWriteStrobeN, // write strobe
  input wire logic packetCommitStrobeN, // packet end strobe
  input wire logic [`SFPS_ADDR_W-1:0] fifoSelectAddress, // endpoint select
  input wire logic [`SFPS_DATA_W-1:0] dataIn, // data bus input
  output logic [`SFPS_DATA_W-1:0] dataOut, // data bus output, registered
  output logic dataOe, // data bus drive, high drives
  output logic fifoFullFlag, // write buffer full
  output logic fifoEmptyFlag, // read buffer empty
  output sfps_entry_s epOutEntry, // entry toward endpoint side
  output logic epOutValid, // entry present
  input wire logic epOutReady, // endpoint side takes entry
  input wire logic [`SFPS_DATA_W-1:0] epInData, // word from endpoint side
  input wire logic epInValid, // word offered
  output logic epInReady // read buffer has room
);

  localparam int EW = $bits(sfps_entry_s);

  sfps_port_s st;
  sfps_port_s next_st;

  logic csAct;
  logic oeAct;
  logic rdAct;
  logic wrAct;
  logic peAct;
  logic clkRise;
  logic wrEv;
  logic rdEv;
  logic peEv;
  logic wrTake;
  logic autoHit;
  sfps_entry_s pushEntry;
  logic pushValid;
  logic pushReady;
  logic [EW-1:0] popBits;
  logic [`SFPS_DATA_W-1:0] headWord;
  logic headValid;
  logic popReq;

  // one polarity input flips every strobe; default is active low
  assign csAct = strobeActiveHigh ? fifoChipSelectN : !fifoChipSelectN;
  assign oeAct = strobeActiveHigh ? fifoOutputEnableN : !fifoOutputEnableN;
  assign peAct = strobeActiveHigh ? packetCommitStrobeN
                                  : !packetCommitStrobeN;
  // read and write are only qualified by chip select
  assign rdAct = csAct && (strobeActiveHigh ? fifoReadStrobeN
                                            : !fifoReadStrobeN);
  assign wrAct = csAct && (strobeActiveHigh ? fifoWriteStrobeN
                                            : !fifoWriteStrobeN);

  // the interface clock is sampled, so its rise is seen at the first clk edge after it
  assign clkRise = interfaceClock && !st.clkPrev;

  // event decode: clocked strobes in sync mode, strobe edges otherwise
  always_comb begin
    if (syncMode) begin
      wrEv = clkRise && wrAct;
      rdEv = clkRise && rdAct;
      peEv = clkRise && peAct;
    end else begin
      // release of write stores; chip select tied on still works
      wrEv = st.wrPrev && !wrAct;
      rdEv = rdAct && !st.rdPrev;
      peEv = peAct && !st.pePrev;
    end
  end

  // in async mode the word is the one sampled before the release
  assign wrTake = wrEv && pushReady;
  assign autoHit = autoMode &&
                   ((st.wordCount + 1'b1) >= autoCommitLength);

  // a write becomes a data entry; a lone commit becomes a marker
  always_comb begin
    pushEntry.isData = 1'b0;
    pushEntry.last = 1'b1;
    pushEntry.addr = syncMode ? fifoSelectAddress : st.addrQ;
    pushEntry.data = `SFPS_RST_WORD;
    pushValid = 1'b0;
    if (wrEv) begin
      pushEntry.isData = 1'b1;
      pushEntry.data = syncMode ? dataIn : st.dataInQ;
      // in sync mode a commit on the same edge closes the packet with this word
      pushEntry.last = (syncMode && peEv) || autoHit;
      pushValid = 1'b1;
    end else if (peEv) begin
      // a later commit closes whatever was written before it
      pushValid = 1'b1;
    end
  end

  // the read buffer pops only on a qualified read, never on enable
  assign popReq = rdEv && headValid;

  // sequencer state update
  always_comb begin
    next_st = st;
    next_st.clkPrev = interfaceClock;
    next_st.wrPrev = wrAct;
    next_st.rdPrev = rdAct;
    next_st.pePrev = peAct;
    // sampled bus word, followed while the write strobe is active, held otherwise
    if (wrAct || !syncMode) begin
      next_st.dataInQ = wrAct ? dataIn : st.dataInQ;
    end
    next_st.addrQ = fifoSelectAddress;
    // word count restarts on every commit, manual or automatic
    if (wrTake) begin
      if (pushEntry.last) begin
        next_st.wordCount = `SFPS_RST_COUNT;
      end else begin
        next_st.wordCount = st.wordCount + 1'b1;
      end
    end else if (peEv && pushReady) begin
      next_st.wordCount = `SFPS_RST_COUNT;
    end
    // sync mode follows the head; after a pop the next word shows
    if (syncMode) begin
      if (headValid) begin
        next_st.rdData = headWord;
      end
    end else if (popReq) begin
      // async read loads the head word, the pop moves the pointer
      next_st.rdData = headWord;
    end
    // between reads async keeps the last word on the bus
    next_st.drive = oeAct;
  end

  // one register set for the whole sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st.clkPrev <= 1'b0;
      st.wrPrev <= 1'b0;
      st.rdPrev <= 1'b0;
      st.pePrev <= 1'b0;
      st.dataInQ <= `SFPS_RST_WORD;
      st.addrQ <= '0;
      st.wordCount <= `SFPS_RST_COUNT;
      st.rdData <= `SFPS_RST_WORD;
      st.drive <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // master-to-endpoint buffer; when full a write is dropped
  sfps_fifo #(
    .WIDTH(EW),
    .DEPTH(`SFPS_FIFO_DEPTH)
  ) u_wrBuf (
    .clk(clk),
    .nrst(nrst),
    .inData(pushEntry),
    .inValid(pushValid),
    .inReady(pushReady),
    .outData(popBits),
    .outValid(epOutValid),
    .outReady(epOutReady)
  );

  // endpoint-to-master buffer; pops only on a master read
  sfps_fifo #(
    .WIDTH(`SFPS_DATA_W),
    .DEPTH(`SFPS_FIFO_DEPTH)
  ) u_rdBuf (
    .clk(clk),
    .nrst(nrst),
    .inData(epInData),
    .inValid(epInValid),
    .inReady(epInReady),
    .outData(headWord),
    .outValid(headValid),
    .outReady(popReq)
  );

  assign epOutEntry = sfps_entry_s'(popBits);

  // flags come from buffer counts, so they move after the pointer edge
  assign fifoFullFlag = !pushReady;
  assign fifoEmptyFlag = !headValid;

  // data out is the registered word; drive follows output enable only
  assign dataOut = st.rdData;
  assign dataOe = st.drive;

endmodule

// *** verif/sfps_port_checker_sva.sv ***
/*
  Pin-level checker for the slave FIFO port.
  Assumes one clock domain and a bind onto sfps_slave_fifo_port.
*/
`timescale 1ns/1ps
module sfps_port_checker
  import sfps_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic syncMode, // mode
  input wire logic strobeActiveHigh, // polarity
  input wire logic interfaceClock, // sampled clock
  input wire logic fifoChipSelectN, // select
  input wire logic fifoOutputEnableN, // enable
  input wire logic fifoReadStrobeN, // read
  input wire logic fifoWriteStrobeN, // write
  input wire logic packetCommitStrobeN, // commit
  input wire logic [`SFPS_DATA_W-1:0] dataIn, // bus in
  input wire logic [`SFPS_DATA_W-1:0] dataOut, // bus out
  input wire logic dataOe, // drive
  input wire logic fifoFullFlag, // full
  input wire logic fifoEmptyFlag, // empty
  input wire sfps_entry_s epOutEntry, // head entry
  input wire logic epOutValid // head present
);
  logic csA, rdA, wrA, peA, oeA, rdGo, wrTake, wrRel;
  logic ifPrev, rdPrev, wrPrev;
  // a strobe is active when it sits at the polarity level
  assign csA = fifoChipSelectN ~^ strobeActiveHigh;
  assign rdA = fifoReadStrobeN ~^ strobeActiveHigh;
  assign wrA = fifoWriteStrobeN ~^ strobeActiveHigh;
  assign peA = packetCommitStrobeN ~^ strobeActiveHigh;
  assign oeA = fifoOutputEnableN ~^ strobeActiveHigh;
  assign rdGo = !syncMode && csA && rdA && !rdPrev;
  assign wrTake = syncMode && interfaceClock && !ifPrev && csA && wrA
    && !fifoFullFlag;
  assign wrRel = !syncMode && wrPrev && !(csA && wrA) && !fifoFullFlag;
  // previous samples, cleared like the port's own so release edges agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ifPrev <= 1'b0;
      rdPrev <= 1'b0;
      wrPrev <= 1'b0;
    end else begin
      ifPrev <= interfaceClock;
      rdPrev <= csA && rdA;
      wrPrev <= csA && wrA;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_fresh; !epOutValid; endsequence
  sequence s_word; epOutValid && epOutEntry.isData; endsequence
  property p_oeLag; $past(nrst) |-> dataOe == $past(oeA); endproperty
  a_oeLag: assert property (p_oeLag)
    else $error("drive not one clock behind enable");
  property p_hold;
    !syncMode && $stable(syncMode) && !rdGo |=> $stable(dataOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read word moved without a read");
  property p_syncWr;
    wrTake ##0 s_fresh |=> s_word and (epOutEntry.data == $past(dataIn));
  endproperty
  a_syncWr: assert property (p_syncWr)
    else $error("clocked write not stored");
  property p_last; wrTake && peA ##0 s_fresh |=> epOutEntry.last; endproperty
  a_last: assert property (p_last)
    else $error("commit missed the last word");
  property p_asyncWr;
    wrRel ##0 s_fresh |=> s_word and (epOutEntry.data == $past(dataIn, 2));
  endproperty
  a_asyncWr: assert property (p_asyncWr)
    else $error("released write not stored");
  property p_full; $rose(fifoFullFlag) |-> $past(wrTake || wrRel || peA);
  endproperty
  a_full: assert property (p_full)
    else $error("full rose with no write");
  property p_sel;
    $rose(epOutValid) && !$past(peA) |-> $past(csA) || $past(csA, 2);
  endproperty
  a_sel: assert property (p_sel)
    else $error("write taken without select");
  property p_empty; $rose(fifoEmptyFlag) |-> $past(csA && rdA); endproperty
  a_empty: assert property (p_empty)
    else $error("empty rose with no read");
endmodule

bind sfps_slave_fifo_port sfps_port_checker i_chk (.*);

// *** verif/sfps_ep_model.sv ***
/*
  Endpoint-side model: takes entries, offers words for reads.
  Assumes valid/ready handshakes sampled on the rising clk edge.
*/
`timescale 1ns/1ps
module sfps_ep_model
  import sfps_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic stall, // refuse entries
  input wire sfps_entry_s epOutEntry, // entry
  input wire logic epOutValid, // entry present
  output logic epOutReady, // entry taken
  output logic [`SFPS_DATA_W-1:0] epInData, // word
  output logic epInValid, // word present
  input wire logic epInReady // port has room
);
  sfps_entry_s got[$];
  logic [`SFPS_DATA_W-1:0] pend[$];
  // stalling lets the port's buffer fill until it refuses
  assign epOutReady = !stall;
  // handshakes complete on the sampling edge
  always @(posedge clk) begin
    if (nrst && epOutValid && epOutReady) got.push_back(epOutEntry);
    if (nrst && epInValid && epInReady) pend.delete(0);
  end
  // an idle data line toggles so stale words never look valid
  always @(negedge clk) begin
    epInValid = nrst && pend.size() > 0;
    epInData = epInValid ? pend[0] : ~epInData;
  end
endmodule

// *** verif/slave_fifo_port_sequencer_tb.sv ***
/*
  Self-checking bench for the slave FIFO port.
  Assumes the endpoint model and the bound checker; drives at negedge.
*/
`timescale 1ns/1ps
`define CHK(g, w) begin totalChecks++; if ((g) !== (w)) begin \
  badCount++; $display("BAD %0t got %h want %h", $time, g, w); end end
module slave_fifo_port_sequencer_tb;
  logic clk = 0, nrst = 0, syncMode = 0, strobeActiveHigh = 0;
  logic autoMode = 0, interfaceClock = 0, stall = 0;
  logic fifoChipSelectN = 1, fifoOutputEnableN = 1, fifoReadStrobeN = 1;
  logic fifoWriteStrobeN = 1, packetCommitStrobeN = 1;
  logic [`SFPS_ADDR_W-1:0] fifoSelectAddress = 2'h1;
  logic [`SFPS_LEN_W-1:0] autoCommitLength = 10'h004;
  logic [`SFPS_DATA_W-1:0] dataIn = 16'h0000, dataOut, epInData;
  logic dataOe, fifoFullFlag, fifoEmptyFlag, epOutValid, epOutReady;
  logic epInValid, epInReady;
  sfps_pkg::sfps_entry_s epOutEntry;
  int badCount = 0, totalChecks = 0;
  always #25 clk = ~clk;
  sfps_slave_fifo_port i_dut (.*);
  sfps_ep_model i_ep (.*);
  task automatic pins(input logic c, o, r, w, p);
    fifoChipSelectN = c ~^ strobeActiveHigh;
    fifoOutputEnableN = o ~^ strobeActiveHigh;
    fifoReadStrobeN = r ~^ strobeActiveHigh;
    fifoWriteStrobeN = w ~^ strobeActiveHigh;
    packetCommitStrobeN = p ~^ strobeActiveHigh;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one interface clock period around strobes already set
  task automatic tick;
    interfaceClock = 1'b1;
    cyc(1);
    interfaceClock = 1'b0;
    cyc(1);
  endtask
  task automatic chkGot(input int i, input logic [17:0] w);
    `CHK({i_ep.got[i].isData, i_ep.got[i].last, i_ep.got[i].data}, w)
  endtask
  // enable alone drives the stale word, then reads with enable tied to read strobe
  task automatic t_asyncRead;
    i_ep.pend.push_back(16'h1111);
    i_ep.pend.push_back(16'h2222);
    // words are queued before enable, so a pop on enable would skew reads
    pins(1, 0, 0, 0, 0);
    cyc(3);
    `CHK(dataOe, 1'b0)
    pins(1, 1, 0, 0, 0);
    cyc(3);
    `CHK(dataOe, 1'b1)
    `CHK(dataOut, 16'h0000)
    `CHK(fifoEmptyFlag, 1'b0)
    for (int k = 0; k < 2; k++) begin
      pins(1, 1, 1, 0, 0);
      cyc(2);
      `CHK(dataOut, 16'h1111 * 16'(k + 1))
      pins(1, 0, 0, 0, 0);
      cyc(2);
    end
    `CHK(dataOe, 1'b0)
    `CHK(fifoEmptyFlag, 1'b1)
  endtask
  // prefetched head, then a two-edge burst read with the strobe held
  task automatic t_syncRead;
    syncMode = 1'b1;
    for (int i = 0; i < 3; i++) i_ep.pend.push_back(16'h3330 + 16'(i));
    pins(1, 1, 0, 0, 0);
    cyc(5);
    `CHK(dataOut, 16'h3330)
    pins(1, 1, 1, 0, 0);
    for (int i = 1; i < 3; i++) begin
      tick; // strobe and enable stay held over the burst
      cyc(1);
      `CHK(dataOut, 16'h3330 + 16'(i))
    end
    pins(0, 0, 0, 0, 0);
  endtask
  // burst into a stalled buffer, then auto commits; a new word each edge
  task automatic t_syncWrite;
    stall = 1'b1;
    for (int i = 0; i < 5; i++) begin
      dataIn = 16'h00A0 + 16'(i);
      pins(1, 0, 0, 1, i == 3);
      tick;
    end
    `CHK(fifoFullFlag, 1'b1)
    stall = 1'b0;
    autoMode = 1'b1;
    autoCommitLength = 10'h002;
    // let the endpoint drain the full buffer so no auto write is dropped
    cyc(5);
    for (int i = 0; i < 3; i++) begin
      dataIn = 16'h00B0 + 16'(i);
      pins(1, 0, 0, 1, i == 2); // commit a period after the auto edge
      tick;
    end
    pins(0, 0, 0, 0, 0);
    cyc(4);
    `CHK(i_ep.got.size(), 7)
    for (int i = 0; i < 4; i++) chkGot(i, {1'b1, i == 3, 16'h00A0 + 16'(i)});
    chkGot(4, {2'b10, 16'h00B0});
    chkGot(5, {2'b11, 16'h00B1});
    chkGot(6, {2'b11, 16'h00B2});
    i_ep.got.delete();
    autoMode = 1'b0;
    syncMode = 1'b0;
  endtask
  // released writes and a later commit, in both polarities
  task automatic t_asyncWrite;
    for (int p = 0; p < 2; p++) begin
      strobeActiveHigh = p[0];
      pins(0, 0, 0, 0, 0);
      cyc(2);
      for (int i = 0; i < 2; i++) begin
        dataIn = 16'h00C0 + 16'(i);
        pins(1, 0, 0, 1, 0);
        cyc(2);
        pins(1, 0, 0, 0, 0); // released well before any commit
        cyc(2);
      end
      pins(1, 0, 0, 0, 1);
      cyc(2);
      pins(1, 0, 0, 0, 0);
      cyc(3);
      chkGot(0, {2'b10, 16'h00C0});
      chkGot(1, {2'b10, 16'h00C1});
      `CHK({i_ep.got[2].isData, i_ep.got[2].last}, 2'b01)
      `CHK(i_ep.got[2].addr, 2'h1)
      i_ep.got.delete();
    end
    strobeActiveHigh = 1'b0;
    pins(0, 0, 0, 0, 0);
  endtask
  task automatic conclude;
    if (badCount == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    nrst = 1'b1;
    cyc(2);
    t_asyncRead;
    t_syncRead;
    t_syncWrite;
    t_asyncWrite;
    conclude;
  end
  // the tests need under a hundred clocks; this allows about two thousand
  initial begin
    #100000;
    badCount++;
    conclude;
  end
endmodule
